// ==== shared/ctg_pkg.sv ====
`default_nettype none

package ctg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // System clock period in ns (125 MHz)
    localparam int CTG_CLK_NS = 8;
    // Worst-case settle time of the gate output after a pin change, ns.
    // Covers both data propagation and enable time with margin for load.
    localparam int CTG_SETTLE_NS = 40;
    // Settle time in clock cycles, rounded up
    localparam int CTG_SETTLE_CYC = (CTG_SETTLE_NS + CTG_CLK_NS - 1) / CTG_CLK_NS;
    // Latency of the readback synchroniser
    localparam int CTG_SYNC_CYC = 2;
    // Cycles spent waiting before the readback is sampled
    localparam int CTG_WAIT_CYC = CTG_SETTLE_CYC + CTG_SYNC_CYC;
    // Width of the wait counter
    localparam int CTG_CNT_W = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Enable pin parks high (output floating) out of reset
    localparam logic CTG_OE_N_RST = 1'h1;
    // Data pins park low out of reset and while disabled
    localparam logic CTG_DATA_RST = 1'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Gate function selected by the user
    typedef enum logic [3:0] {
        CTG_MODE_OFF,
        CTG_MODE_BUF,
        CTG_MODE_INV,
        CTG_MODE_MUX,
        CTG_MODE_MUX_INV,
        CTG_MODE_AND,
        CTG_MODE_NAND,
        CTG_MODE_XOR,
        CTG_MODE_XNOR
    } ctg_mode_t;

    // Pins driven toward the gate
    typedef struct packed {
        logic oe_n;           // Active-low output enable
        logic polarity_flip;  // Output inversion input
        logic path_steer;     // Selects second_operand when high
        logic second_operand; // Operand taken when path_steer is high
        logic first_operand;  // Operand taken when path_steer is low
    } ctg_pins_t;

    // User request
    typedef struct packed {
        ctg_mode_t mode;  // Function to configure
        logic op_a;       // First logic input
        logic op_b;       // Second logic input
        logic sel;        // Multiplexer select
    } ctg_req_t;

    // Answer to a request
    typedef struct packed {
        logic y;         // Sampled gate output
        logic match;     // Sampled output equals expected value
        logic disabled;  // Gate output was floating, no sample taken
    } ctg_rsp_t;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Logic value of the gate for a given pin pattern while enabled
    function automatic logic ctg_gate_eval(input ctg_pins_t p);
        logic pick;
        pick = p.path_steer ? p.second_operand : p.first_operand;
        return p.polarity_flip ^ pick;
    endfunction

endpackage

`default_nettype wire

// ==== hdl/ctg_sync.sv ====
`default_nettype none

// ------------------------------------------------------------
// Two-flop synchroniser for the gate readback
// ------------------------------------------------------------
module ctg_sync (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q; // First stage, read by the second stage only

    // Both stages clear to low on reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_q <= 1'h0;
            sync_out <= 1'h0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ==== hdl/ctg_host.sv ====
`default_nettype none

// Function
// [RL1] Enable high floats output; inputs ignored
// [RL2] Enabled output equals flip XOR selected operand
// [RL3] Floating data inputs harmless while disabled
// [RL4] Mux: flip low, steer picks operand
// [RL5] Inverted mux: flip high, complement selected
// [RL6] first and flip low give AND
// [RL7] first low, flip high give NAND
// [RL8] Steer low gives XOR; first high XNOR
// [RL9] Buffer or inverter of first operand
// [RL10] Gate is combinational with tri-state enable

module ctg_host (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic req_valid,
    input wire ctg_pkg::ctg_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output ctg_pkg::ctg_rsp_t rsp,
    output ctg_pkg::ctg_pins_t gate_pins,
    input wire logic gate_y
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTG_ST_IDLE,
        CTG_ST_WAIT
    } ctg_state_t;

    ctg_state_t state_q;              // Sequencer state
    ctg_pkg::ctg_pins_t pins_q;       // Registered pin pattern
    ctg_pkg::ctg_pins_t pins_d;       // Pin pattern for a new request
    logic expect_q;                   // Expected output of the gate
    logic [ctg_pkg::CTG_CNT_W-1:0] cnt_q; // Settle counter
    logic ready_q;                    // Registered ready
    logic rsp_valid_q;                // One-cycle answer strobe
    ctg_pkg::ctg_rsp_t rsp_q;         // Registered answer
    logic y_sync;                     // Synchronised readback
    logic take;                       // Request accepted this cycle
    logic wait_done;                  // Settle window over

    // Last count value of the wait window
    localparam logic [ctg_pkg::CTG_CNT_W-1:0] CTG_CNT_LAST =
        ctg_pkg::CTG_CNT_W'(ctg_pkg::CTG_WAIT_CYC - 1);

    assign take = req_valid && ready_q;
    assign wait_done = (state_q == CTG_ST_WAIT) && (cnt_q == CTG_CNT_LAST);

    // ------------------------------------------------------------
    // Readback synchroniser
    // ------------------------------------------------------------
    // Gate output comes from a pin, so it is brought in through two flops
    ctg_sync u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(gate_y),
        .sync_out(y_sync)
    );

    // ------------------------------------------------------------
    // Pin pattern for each function
    // ------------------------------------------------------------
    // Translates the user's mode and operands into the four data pins.
    // Every pattern parks unused pins at a fixed level rather than
    // leaving them to float, so the pattern is one of the sixteen.
    always_comb begin
        pins_d.oe_n = 1'h0;
        pins_d.polarity_flip = ctg_pkg::CTG_DATA_RST;
        pins_d.path_steer = ctg_pkg::CTG_DATA_RST;
        pins_d.second_operand = ctg_pkg::CTG_DATA_RST;
        pins_d.first_operand = ctg_pkg::CTG_DATA_RST;
        unique case (req.mode)
            ctg_pkg::CTG_MODE_OFF: begin
                // Float the output; data pins park low
                pins_d.oe_n = 1'h1; // [RL1]
            end
            ctg_pkg::CTG_MODE_BUF: begin
                // Steer and flip low pass first operand unchanged
                pins_d.first_operand = req.op_a; // [RL9]
            end
            ctg_pkg::CTG_MODE_INV: begin
                // Flip high inverts first operand
                pins_d.first_operand = req.op_a; // [RL9]
                pins_d.polarity_flip = 1'h1;
            end
            ctg_pkg::CTG_MODE_MUX: begin
                // Flip held low for a true selector
                pins_d.first_operand = req.op_a; // [RL4]
                pins_d.second_operand = req.op_b;
                pins_d.path_steer = req.sel;
            end
            ctg_pkg::CTG_MODE_MUX_INV: begin
                // Flip held high gives inverted selector
                pins_d.first_operand = req.op_a; // [RL5]
                pins_d.second_operand = req.op_b;
                pins_d.path_steer = req.sel;
                pins_d.polarity_flip = 1'h1;
            end
            ctg_pkg::CTG_MODE_AND: begin
                // First operand and flip low: second AND steer
                pins_d.second_operand = req.op_a; // [RL6]
                pins_d.path_steer = req.op_b;
            end
            ctg_pkg::CTG_MODE_NAND: begin
                // First operand low, flip high: NAND
                pins_d.second_operand = req.op_a; // [RL7]
                pins_d.path_steer = req.op_b;
                pins_d.polarity_flip = 1'h1;
            end
            ctg_pkg::CTG_MODE_XOR: begin
                // Steer low: first operand XOR flip
                pins_d.first_operand = req.op_a; // [RL8]
                pins_d.polarity_flip = req.op_b;
            end
            ctg_pkg::CTG_MODE_XNOR: begin
                // First operand high, steer as input: XNOR
                pins_d.first_operand = 1'h1; // [RL8]
                pins_d.path_steer = req.op_a;
                pins_d.polarity_flip = req.op_b;
            end
            default: begin
                // Unused mode codes float the output, the safe choice
                pins_d.oe_n = 1'h1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Idle until a request is taken, then wait out the settle window
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= CTG_ST_IDLE;
        end else begin
            unique case (state_q)
                CTG_ST_IDLE: begin
                    // New pattern goes out; start waiting
                    if (take) begin
                        state_q <= CTG_ST_WAIT;
                    end
                end
                CTG_ST_WAIT: begin
                    // Window over; answer and accept again
                    if (wait_done) begin
                        state_q <= CTG_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Settle counter, cleared at each accepted request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (take) begin
            cnt_q <= '0;
        end else if (state_q == CTG_ST_WAIT) begin
            cnt_q <= cnt_q + ctg_pkg::CTG_CNT_W'(1);
        end
    end

    // Ready drops while a request is in flight, so pins never change
    // before the previous answer has been sampled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ready_q <= 1'h0;
        end else if (take) begin
            ready_q <= 1'h0;
        end else if (state_q == CTG_ST_IDLE || wait_done) begin
            ready_q <= 1'h1;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Pins hold their pattern until the next request. Reset floats
    // the gate output so the shared line is never driven by surprise.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pins_q.oe_n <= ctg_pkg::CTG_OE_N_RST; // [RL1]
            pins_q.polarity_flip <= ctg_pkg::CTG_DATA_RST;
            pins_q.path_steer <= ctg_pkg::CTG_DATA_RST;
            pins_q.second_operand <= ctg_pkg::CTG_DATA_RST;
            pins_q.first_operand <= ctg_pkg::CTG_DATA_RST;
        end else if (take) begin
            pins_q <= pins_d;
        end
    end

    // Expected output from the same pattern that goes to the pins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            expect_q <= 1'h0;
        end else if (take) begin
            expect_q <= ctg_pkg::ctg_gate_eval(pins_d); // [RL2]
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    // Strobe lasts one cycle when the window ends
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rsp_valid_q <= 1'h0;
        end else begin
            rsp_valid_q <= wait_done;
        end
    end

    // Sample and compare. A floating output carries no level, so the
    // readback is not looked at and the match is reported as good;
    // the gate itself ignores its inputs then.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rsp_q <= '0;
        end else if (wait_done) begin
            if (pins_q.oe_n) begin
                rsp_q.y <= 1'h0; // [RL3]
                rsp_q.match <= 1'h1;
                rsp_q.disabled <= 1'h1; // [RL10]
            end else begin
                rsp_q.y <= y_sync;
                rsp_q.match <= (y_sync == expect_q); // [RL2]
                rsp_q.disabled <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign gate_pins = pins_q;
    assign req_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp = rsp_q;

endmodule

`default_nettype wire

// ==== tb/ctg_gate_model.sv ====
`default_nettype none

// ------------------------------------------------------------
// Behavioural gate on the far side of the pins
// ------------------------------------------------------------
module ctg_gate_model (
    input wire logic clk_sys,
    input wire ctg_pkg::ctg_pins_t gate_pins,
    input wire logic fault,
    output logic gate_y
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pick; // Operand chosen by the steer pin
    logic slow_y; // Driven level after the slow path
    logic slow_en; // Driver enable after the slow path
    logic float_q = 1'b0; // Undriven net wanders, never settles
    // Steer picks the operand
    assign pick = gate_pins.path_steer ? gate_pins.second_operand : gate_pins.first_operand;
    // Flip and forced fault; slow but inside the settle budget
    assign #30 slow_y = gate_pins.polarity_flip ^ pick ^ fault;
    assign #30 slow_en = !gate_pins.oe_n;
    // Float toggles so a stale sample cannot pass by luck
    always @(posedge clk_sys) float_q <= ~float_q;
    // No storage: pure selection of driver or float
    assign gate_y = slow_en ? slow_y : float_q;
endmodule

`default_nettype wire

// ==== tb/ctg_host_properties.sv ====
`default_nettype none

module ctg_host_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic req_valid,
    input wire ctg_pkg::ctg_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire ctg_pkg::ctg_rsp_t rsp,
    input wire ctg_pkg::ctg_pins_t gate_pins,
    input wire logic gate_y
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic take; // Request accepted this edge
    assign take = req_valid && req_ready;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pins each mode must drive; unknown codes park the gate
    function automatic logic [4:0] pins_of(input ctg_pkg::ctg_req_t r);
        case (r.mode)
            ctg_pkg::CTG_MODE_BUF: return {4'h0, r.op_a};
            ctg_pkg::CTG_MODE_INV: return {4'h4, r.op_a};
            ctg_pkg::CTG_MODE_MUX: return {2'h0, r.sel, r.op_b, r.op_a};
            ctg_pkg::CTG_MODE_MUX_INV: return {2'h1, r.sel, r.op_b, r.op_a};
            ctg_pkg::CTG_MODE_AND: return {2'h0, r.op_b, r.op_a, 1'h0};
            ctg_pkg::CTG_MODE_NAND: return {2'h1, r.op_b, r.op_a, 1'h0};
            ctg_pkg::CTG_MODE_XOR: return {1'h0, r.op_b, 2'h0, r.op_a};
            ctg_pkg::CTG_MODE_XNOR: return {1'h0, r.op_b, r.op_a, 2'h1};
            default: return 5'h10;
        endcase
    endfunction
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Window end at edge N+7 is seen at N+8: seven low samples, then answer
    a_busy_window: assert property (take |=> !req_ready [*7] ##1 (req_ready && rsp_valid))
        else $error("answer or ready timing wrong");
    a_pin_map: assert property (take |=> gate_pins == pins_of($past(req)))
        else $error("pin pattern wrong for mode");
    // Next take may fall at N+8, so stability is claimed up to that edge only
    a_pin_stable: assert property (take |=> ##1 $stable(gate_pins) [*7])
        else $error("pins moved during a request");
    a_pins_on_take: assert property ($changed(gate_pins) |-> $past(take))
        else $error("pins changed without a request");
    a_park_low: assert property (gate_pins.oe_n |-> gate_pins[3:0] == 4'h0)
        else $error("data pins not parked while disabled");
    a_rsp_disabled: assert property (rsp_valid |-> rsp.disabled == gate_pins.oe_n)
        else $error("disabled flag disagrees with enable");
    a_off_answer: assert property (rsp_valid && rsp.disabled |-> !rsp.y && rsp.match)
        else $error("floating answer not neutral");
    a_match_eval: assert property (rsp_valid && !rsp.disabled |-> rsp.match == (rsp.y ==
        (gate_pins.polarity_flip ^ (gate_pins.path_steer ? gate_pins.second_operand
        : gate_pins.first_operand))))
        else $error("match flag wrong");
    a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp))
        else $error("answer changed between pulses");
    a_reset_park: assert property (disable iff (1'b0) reset |=>
        gate_pins == 5'h10 && !req_ready && !rsp_valid)
        else $error("outputs not parked in reset");
    c_and: cover property (take && req.mode == ctg_pkg::CTG_MODE_AND);
    c_off: cover property (rsp_valid && rsp.disabled);
    c_miss: cover property (rsp_valid && !rsp.match);
endmodule

bind ctg_host ctg_host_properties u_props (.clk_sys(clk_sys), .reset(reset),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .gate_pins(gate_pins), .gate_y(gate_y));

`default_nettype wire

// ==== tb/configurable_tristate_gate_tb_top.sv ====
`default_nettype none

module configurable_tristate_gate_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic fault = 1'b0; // Forces the gate to answer wrongly
    ctg_pkg::ctg_req_t req = '0;
    ctg_pkg::ctg_req_t r;
    logic req_ready, rsp_valid, gate_y;
    ctg_pkg::ctg_rsp_t rsp;
    ctg_pkg::ctg_pins_t gate_pins;
    ctg_pkg::ctg_rsp_t exp_q[$]; // Expected answers, oldest first
    int failures = 0;
    int samples_checked = 0;
    int seed = 60;
    always #4 clk_sys = ~clk_sys;
    ctg_host u_dut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .gate_pins(gate_pins),
        .gate_y(gate_y));
    ctg_gate_model u_gate (.clk_sys(clk_sys), .gate_pins(gate_pins), .fault(fault),
        .gate_y(gate_y));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Answer the gate gives, wrong output and a miss when f is set; unknown codes and off float
    function automatic ctg_pkg::ctg_rsp_t expect_of(input ctg_pkg::ctg_req_t q, input logic f);
        ctg_pkg::ctg_rsp_t e;
        logic v;
        e = '0;
        v = 1'b0;
        case (q.mode)
            ctg_pkg::CTG_MODE_BUF: v = q.op_a;
            ctg_pkg::CTG_MODE_INV: v = !q.op_a;
            ctg_pkg::CTG_MODE_MUX: v = q.sel ? q.op_b : q.op_a;
            ctg_pkg::CTG_MODE_MUX_INV: v = !(q.sel ? q.op_b : q.op_a);
            ctg_pkg::CTG_MODE_AND: v = q.op_a & q.op_b;
            ctg_pkg::CTG_MODE_NAND: v = !(q.op_a & q.op_b);
            ctg_pkg::CTG_MODE_XOR: v = q.op_a ^ q.op_b;
            ctg_pkg::CTG_MODE_XNOR: v = !(q.op_a ^ q.op_b);
            default: e.disabled = 1'b1;
        endcase
        e.y = e.disabled ? 1'b0 : v ^ f;
        e.match = e.disabled | !f;
        return e;
    endfunction
    // Hold the request until ready is seen, then note the answer
    task automatic send(input ctg_pkg::ctg_req_t q);
        int n;
        n = 0;
        req <= q;
        req_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        if (n >= 40) begin
            check(1'b0, "request never taken");
            finish_test();
        end
        exp_q.push_back(expect_of(q, fault));
        #1;
    endtask
    // Drop valid and wait for every answer outstanding
    task automatic drain();
        int n;
        n = 0;
        req_valid <= 1'b0;
        while (exp_q.size() != 0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        check(exp_q.size() == 0, "answer missing");
        // A lost answer ends the run at once
        if (exp_q.size() != 0) begin
            finish_test();
        end
        #1;
    endtask
    // Monitor: each answer pulse takes the oldest note
    always @(posedge clk_sys) begin
        if (!reset && rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) check(1'b0, "unexpected answer");
            else check(rsp === exp_q.pop_front(), "answer mismatch");
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        // Every mode code and operand set, back to back
        for (int m = 0; m < 16; m++) begin
            for (int k = 0; k < 8; k++) begin
                r.mode = ctg_pkg::ctg_mode_t'(m[3:0]);
                {r.op_a, r.op_b, r.sel} = k[2:0];
                send(r);
            end
        end
        // Random traffic including unknown codes
        repeat (40) send(ctg_pkg::ctg_req_t'($random(seed)));
        drain();
        // Broken gate must be reported as a miss
        fault = 1'b1;
        // Operands are three bits: op_a, op_b, sel
        for (int m = 1; m < 9; m++) send(ctg_pkg::ctg_req_t'({m[3:0], 3'h5}));
        drain();
        fault = 1'b0;
        // Reset in mid-request parks the pins and drops the answer
        send(ctg_pkg::ctg_req_t'({ctg_pkg::CTG_MODE_AND, 3'h6}));
        req_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b1;
        exp_q.delete();
        repeat (2) @(posedge clk_sys);
        #1;
        check(gate_pins === 5'h10 && req_ready === 1'b0, "reset did not park");
        reset = 1'b0;
        send(ctg_pkg::ctg_req_t'({ctg_pkg::CTG_MODE_NAND, 3'h6}));
        drain();
        finish_test();
    end
endmodule

`default_nettype wire
